// *** verilog/link_ack_pkg.sv ***
package link_ack_pkg;
    localparam int SEQ_W = 12;
    localparam logic [11:0] SEQ_RESET = 12'h000;
    localparam logic [11:0] SEQ_ONE = 12'h001;
    localparam logic [11:0] ACKED_RESET = 12'hFFF;
    localparam logic [11:0] DUP_WINDOW = 12'h800;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = 12;
    localparam logic [15:0] TIMER_RESET = 16'h0000;
    localparam logic [15:0] TIMER_MAX = 16'hFFFF;
    localparam logic [3:0] FAIR_LIMIT = 4'hF;
    // control packet type codes
    localparam logic [7:0] DLLP_ACK = 8'h01;
    localparam logic [7:0] DLLP_NAK = 8'h02;
    localparam logic [7:0] DLLP_FC = 8'h03;
    localparam logic [7:0] DLLP_PM = 8'h04;
    // grant bit positions, highest priority first
    localparam int GNT_N = 7;
    localparam int GNT_NAK = 0;
    localparam int GNT_ACK = 1;
    localparam int GNT_FCM = 2;
    localparam int GNT_REPLAY = 3;
    localparam int GNT_TLP = 4;
    localparam int GNT_FCO = 5;
    localparam int GNT_OTHER = 6;
    localparam logic [6:0] LOW_CLASSES = 7'h60;
    typedef enum logic [1:0] {
        ARB_IDLE = 2'b01,
        ARB_WAIT = 2'b10
    } arb_state_t;
endpackage

// *** verilog/seq_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module seq_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [AW:0] count, next_count;
    logic push, pop;

    // flags come from the count flop, so full and empty are exact
    assign inReady = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // pointer and count update
    always_comb begin
        next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    // storage has no reset; only written words are ever read
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end
endmodule
`default_nettype wire

// *** verilog/link_ack_nak.sv ***
`timescale 1ns/1ps
`default_nettype none
module link_ack_nak (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // link state: low is the inactive state
    input wire logic linkActive,
    input wire logic rxError,
    // received control packets
    input wire logic dllpValid,
    input wire logic [7:0] dllpType,
    input wire logic [23:0] dllpBody,
    input wire logic [15:0] dllpCrcField,
    input wire logic [15:0] dllpCrcCalc,
    // received packets
    input wire logic tlpRxActive,
    input wire logic tlpEnd,
    input wire logic [11:0] tlpSeq,
    input wire logic tlpNullified,
    input wire logic [31:0] tlpCrcField,
    input wire logic [31:0] tlpCrcCalc,
    output logic tlpReady,
    // forwarding to the transaction layer
    output logic fwdValid,
    input wire logic fwdReady,
    output logic [11:0] fwdSeq,
    // control packets passed upward
    output logic fcValid,
    output logic [23:0] fcData,
    output logic pmValid,
    output logic [23:0] pmData,
    // transmit requests and arbitration
    input wire logic txTlpSent,
    input wire logic txDone,
    input wire logic fcMandReq,
    input wire logic tlpReq,
    input wire logic fcOtherReq,
    input wire logic otherReq,
    input wire logic [15:0] ackLatencyLimit,
    output logic [6:0] grant,
    output logic [11:0] replySequence,
    // status
    output logic [11:0] expectedRxSequence,
    output logic [11:0] lastAckedSequence,
    output logic retryEmpty,
    output logic purge,
    output logic replayTimerReset,
    output logic portError,
    output logic protocolError,
    output logic tlpMissing
);
    // lowest set bit of a request vector
    function automatic logic [6:0] pickFirst(input logic [6:0] req);
        pickFirst = req & (~req + 7'h01);
    endfunction

    // modulo-4096 distance between two sequence values
    function automatic logic [11:0] seqDist(input logic [11:0] a, input logic [11:0] b);
        seqDist = a - b;
    endfunction

    logic [11:0] nextTxSeq, next_nextTxSeq, next_lastAcked;
    logic next_retryEmpty, next_purge, next_replayTimerReset;
    logic next_fcValid, next_pmValid, next_protocolError;
    logic [23:0] next_fcData, next_pmData;
    logic dllpTake, dllpCrcBad, ackAccept, nakAccept, seqKnown;
    logic [11:0] ackSeq, outstanding, ackDist;

    assign dllpTake = dllpValid && !rxError;
    assign dllpCrcBad = dllpTake && (dllpCrcField != dllpCrcCalc);
    // only the sequence bits are looked at; reserved body bits never matter
    assign ackSeq = dllpBody[11:0];
    assign outstanding = seqDist(nextTxSeq - link_ack_pkg::SEQ_ONE, lastAckedSequence);
    assign ackDist = seqDist(ackSeq, lastAckedSequence);
    assign seqKnown = (ackDist <= outstanding);

    // control packet receive and retry bookkeeping, one packet per cycle
    always_comb begin
        next_fcValid = 1'b0;
        next_fcData = fcData;
        next_pmValid = 1'b0;
        next_pmData = pmData;
        next_protocolError = 1'b0;
        next_purge = 1'b0;
        next_replayTimerReset = 1'b0;
        next_lastAcked = lastAckedSequence;
        ackAccept = 1'b0;
        nakAccept = 1'b0;
        next_nextTxSeq = nextTxSeq + 12'(txTlpSent);
        if (dllpTake && !dllpCrcBad) begin
            case (dllpType)
                link_ack_pkg::DLLP_FC: begin
                    next_fcValid = 1'b1;
                    next_fcData = dllpBody;
                end
                link_ack_pkg::DLLP_PM: begin
                    next_pmValid = 1'b1;
                    next_pmData = dllpBody;
                end
                link_ack_pkg::DLLP_ACK, link_ack_pkg::DLLP_NAK: begin
                    if (!seqKnown) begin
                        next_protocolError = 1'b1;
                    end else begin
                        ackAccept = 1'b1;
                        nakAccept = (dllpType == link_ack_pkg::DLLP_NAK);
                        if (ackDist != link_ack_pkg::SEQ_RESET) begin
                            next_purge = 1'b1;
                            next_lastAcked = ackSeq;
                            next_replayTimerReset = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        if (!linkActive) begin
            next_nextTxSeq = link_ack_pkg::SEQ_RESET;
            next_lastAcked = link_ack_pkg::ACKED_RESET;
        end
        next_retryEmpty = (next_nextTxSeq - link_ack_pkg::SEQ_ONE == next_lastAcked);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fcValid <= 1'b0;
            fcData <= '0;
            pmValid <= 1'b0;
            pmData <= '0;
            protocolError <= 1'b0;
            purge <= 1'b0;
            replayTimerReset <= 1'b0;
            lastAckedSequence <= link_ack_pkg::ACKED_RESET;
            nextTxSeq <= link_ack_pkg::SEQ_RESET;
            retryEmpty <= 1'b1;
        end else begin
            fcValid <= next_fcValid;
            fcData <= next_fcData;
            pmValid <= next_pmValid;
            pmData <= next_pmData;
            protocolError <= next_protocolError;
            purge <= next_purge;
            replayTimerReset <= next_replayTimerReset;
            lastAckedSequence <= next_lastAcked;
            nextTxSeq <= next_nextTxSeq;
            retryEmpty <= next_retryEmpty;
        end
    end

    logic [11:0] next_expected, rxDist;
    logic nakScheduled, next_nakScheduled, unackedFwd, next_unackedFwd;
    logic next_portError, next_tlpMissing, nakEvent, ackEvent, ackDue;
    logic pushValid, fifoInReady, fwdPop, tlpTake;
    logic [15:0] ackTimer, next_ackTimer;
    logic ackReq, nakReq;

    // error ends the packet, so a clashing end is not taken
    assign tlpTake = tlpEnd && !rxError;
    assign rxDist = seqDist(expectedRxSequence, tlpSeq);
    assign fwdPop = fwdValid && fwdReady;
    assign ackDue = linkActive && unackedFwd && !nakScheduled && !ackReq && (ackTimer >= ackLatencyLimit);

    // packet receive checks and reply scheduling
    always_comb begin
        next_expected = expectedRxSequence;
        next_nakScheduled = nakScheduled;
        next_portError = dllpCrcBad;
        next_tlpMissing = 1'b0;
        nakEvent = 1'b0;
        ackEvent = 1'b0;
        pushValid = 1'b0;
        if (rxError && tlpRxActive) begin
            nakEvent = !nakScheduled;
        end else if (tlpTake) begin
            if (tlpNullified) begin
                if (tlpCrcField != ~tlpCrcCalc) begin
                    next_portError = 1'b1;
                    nakEvent = !nakScheduled;
                end
            end else if (tlpCrcField != tlpCrcCalc) begin
                next_portError = 1'b1;
                nakEvent = !nakScheduled;
            end else if (tlpSeq != expectedRxSequence) begin
                if (rxDist <= link_ack_pkg::DUP_WINDOW) begin
                    ackEvent = 1'b1;
                end else if (!nakScheduled) begin
                    nakEvent = 1'b1;
                    next_tlpMissing = 1'b1;
                end
            end else if (fifoInReady) begin
                pushValid = 1'b1;
                next_expected = expectedRxSequence + link_ack_pkg::SEQ_ONE;
                next_nakScheduled = 1'b0;
            end
        end
        if (nakEvent) begin
            next_nakScheduled = 1'b1;
        end
        next_unackedFwd = (unackedFwd && !grant[link_ack_pkg::GNT_ACK]) || fwdPop;
        if (!next_unackedFwd || nakEvent || ackEvent || ackDue) begin
            next_ackTimer = link_ack_pkg::TIMER_RESET;
        end else if (ackTimer != link_ack_pkg::TIMER_MAX) begin
            next_ackTimer = ackTimer + 16'h0001;
        end else begin
            next_ackTimer = ackTimer;
        end
        if (!linkActive) begin
            next_expected = link_ack_pkg::SEQ_RESET;
            next_nakScheduled = 1'b0;
            next_unackedFwd = 1'b0;
            next_ackTimer = link_ack_pkg::TIMER_RESET;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            expectedRxSequence <= link_ack_pkg::SEQ_RESET;
            nakScheduled <= 1'b0;
            unackedFwd <= 1'b0;
            ackTimer <= link_ack_pkg::TIMER_RESET;
            portError <= 1'b0;
            tlpMissing <= 1'b0;
            tlpReady <= 1'b0;
        end else begin
            expectedRxSequence <= next_expected;
            nakScheduled <= next_nakScheduled;
            unackedFwd <= next_unackedFwd;
            ackTimer <= next_ackTimer;
            portError <= next_portError;
            tlpMissing <= next_tlpMissing;
            tlpReady <= fifoInReady;
        end
    end

    // in-order sequences wait here until the transaction layer takes them
    seq_fifo #(
        .WIDTH(link_ack_pkg::FIFO_W),
        .DEPTH(link_ack_pkg::FIFO_DEPTH)
    ) fwdFifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .inValid(pushValid),
        .inReady(fifoInReady),
        .inData(tlpSeq),
        .outValid(fwdValid),
        .outReady(fwdReady),
        .outData(fwdSeq)
    );

    link_ack_pkg::arb_state_t arbState, next_arbState;
    logic next_ackReq, next_nakReq, replayPending, next_replayPending;
    logic [6:0] req, pick, next_grant;
    logic [11:0] next_replySequence;
    logic [3:0] fairCount, next_fairCount;

    // priority order; new packets are held back while a replay waits
    assign req = {otherReq, fcOtherReq, tlpReq && !replayPending, replayPending && !retryEmpty,
                  fcMandReq, ackReq, nakReq};

    // transmit arbiter: one grant per finished transmission
    always_comb begin
        next_ackReq = ackReq;
        next_nakReq = nakReq;
        next_replayPending = replayPending;
        next_grant = '0;
        next_arbState = arbState;
        next_fairCount = fairCount;
        next_replySequence = replySequence;
        pick = pickFirst(req);
        // fairness for low classes, never ahead of replies
        if (fairCount == link_ack_pkg::FAIR_LIMIT && req[1:0] == 2'b00
            && (req & link_ack_pkg::LOW_CLASSES) != '0) begin
            pick = pickFirst(req & link_ack_pkg::LOW_CLASSES);
        end
        case (arbState)
            link_ack_pkg::ARB_IDLE: begin
                if (req != '0) begin
                    next_grant = pick;
                    next_arbState = link_ack_pkg::ARB_WAIT;
                    if ((pick & link_ack_pkg::LOW_CLASSES) != '0) begin
                        next_fairCount = '0;
                    end else if ((req & link_ack_pkg::LOW_CLASSES) != '0 && fairCount != link_ack_pkg::FAIR_LIMIT) begin
                        next_fairCount = fairCount + 4'h1;
                    end
                end
            end
            link_ack_pkg::ARB_WAIT: begin
                if (txDone) begin
                    next_arbState = link_ack_pkg::ARB_IDLE;
                end
            end
            default: begin
                next_arbState = link_ack_pkg::ARB_IDLE;
            end
        endcase
        if (next_grant[link_ack_pkg::GNT_NAK] || next_grant[link_ack_pkg::GNT_ACK]) begin
            next_replySequence = expectedRxSequence - link_ack_pkg::SEQ_ONE;
        end
        // clear first so a same-cycle schedule wins
        if (next_grant[link_ack_pkg::GNT_ACK]) begin
            next_ackReq = 1'b0;
        end
        if (next_grant[link_ack_pkg::GNT_NAK]) begin
            next_nakReq = 1'b0;
        end
        if (next_grant[link_ack_pkg::GNT_REPLAY] || retryEmpty) begin
            next_replayPending = 1'b0;
        end
        if (ackEvent || ackDue) begin
            next_ackReq = 1'b1;
        end
        if (nakEvent) begin
            next_nakReq = 1'b1;
        end
        if (nakAccept) begin
            next_replayPending = 1'b1;
        end
        if (!linkActive) begin
            next_ackReq = 1'b0;
            next_nakReq = 1'b0;
            next_replayPending = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            arbState <= link_ack_pkg::ARB_IDLE;
            grant <= '0;
            ackReq <= 1'b0;
            nakReq <= 1'b0;
            replayPending <= 1'b0;
            fairCount <= '0;
            replySequence <= link_ack_pkg::SEQ_RESET;
        end else begin
            arbState <= next_arbState;
            grant <= next_grant;
            ackReq <= next_ackReq;
            nakReq <= next_nakReq;
            replayPending <= next_replayPending;
            fairCount <= next_fairCount;
            replySequence <= next_replySequence;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    chk_grant_onehot: assert property ((grant != '0) |-> $onehot(grant))
        else $error("grant not one-hot");
    chk_busy_hold: assert property (((grant != '0) && !txDone) |=> (grant == '0))
        else $error("grant issued during transmission");
    chk_nak_first: assert property ((arbState == link_ack_pkg::ARB_IDLE && nakReq) |=> grant[0])
        else $error("pending Nak not granted first");
    chk_dllp_crc: assert property (dllpCrcBad |=> portError && !fcValid && !pmValid)
        else $error("corrupt control packet not flagged");
    chk_fc_pass: assert property ((dllpTake && !dllpCrcBad && dllpType == link_ack_pkg::DLLP_FC) |=> fcValid)
        else $error("flow packet not passed");
    chk_bad_seq: assert property ((dllpTake && !dllpCrcBad && dllpType == link_ack_pkg::DLLP_ACK && !seqKnown)
        |=> protocolError && $stable(lastAckedSequence))
        else $error("unknown reply sequence accepted");
    chk_purge_load: assert property ((ackAccept && ackDist != '0 && linkActive) |=> purge && replayTimerReset
        && lastAckedSequence == $past(ackSeq))
        else $error("newer reply did not purge");
    chk_inactive_clr: assert property (!linkActive
        |=> expectedRxSequence == '0 && !nakScheduled && ackTimer == '0)
        else $error("state not cleared while inactive");
    chk_dup_ack: assert property ((ackEvent && linkActive) |=> ackReq)
        else $error("duplicate did not schedule Ack");
    chk_reply_seq: assert property ((next_grant[1] || next_grant[0])
        |=> replySequence == $past(expectedRxSequence) - 12'h001)
        else $error("reply sequence wrong");

    cov_ack_sent: cover property (ackReq ##[1:20] grant[1]);
    cov_nak_replay: cover property (nakAccept ##[1:30] grant[3]);
    cov_fifo_full: cover property (!fifoInReady);
    cov_fair_grant: cover property (fairCount == link_ack_pkg::FAIR_LIMIT ##1 grant[6]);
endmodule
`default_nettype wire

// *** dv/link_partner_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
    // clock
    input wire logic clk_sys,
    // control packets toward the block
    output logic dllpValid,
    output logic [7:0] dllpType,
    output logic [23:0] dllpBody,
    output logic [15:0] dllpCrcField,
    output logic [15:0] dllpCrcCalc,
    // packets toward the block
    output logic tlpRxActive,
    output logic tlpEnd,
    output logic [11:0] tlpSeq,
    output logic tlpNullified,
    output logic [31:0] tlpCrcField,
    output logic [31:0] tlpCrcCalc,
    output logic rxError
);
    // idle lines; computed checks stay fixed so only the received field varies
    initial begin
        {dllpValid, dllpType, dllpBody, dllpCrcField, tlpRxActive, tlpEnd, tlpSeq, tlpNullified, rxError} = '0;
        dllpCrcCalc = 16'h5A3C;
        tlpCrcCalc = 32'h1234ABCD;
        tlpCrcField = 32'h0;
    end
    // one control packet; the body flips after release so stale data never matches
    task automatic send_dllp(input logic [7:0] t, input logic [23:0] b, input logic ok, input logic err);
        @(posedge clk_sys);
        #10;
        {dllpValid, dllpType, dllpBody, rxError} = {1'b1, t, b, err};
        dllpCrcField = ok ? 16'h5A3C : 16'hA5C3;
        @(posedge clk_sys);
        #10;
        {dllpValid, rxError} = 2'b00;
        dllpBody = ~b;
    endtask
    // kind 0 good, 1 bad check, 2 nullified quiet, 3 nullified corrupt, 4 receiver error
    task automatic send_tlp(input logic [11:0] s, input logic [2:0] k);
        @(posedge clk_sys);
        #10;
        tlpRxActive = 1'b1;
        @(posedge clk_sys);
        #10;
        {tlpSeq, tlpNullified, tlpEnd, rxError} = {s, k[1], k != 3'h4, k == 3'h4};
        tlpCrcField = (k == 3'h0) ? 32'h1234ABCD : (k == 3'h2) ? ~32'h1234ABCD : 32'h0BAD0BAD;
        @(posedge clk_sys);
        #10;
        {tlpRxActive, tlpEnd, rxError} = 3'h0;
        tlpSeq = ~s;
    endtask
endmodule
`default_nettype wire

// *** dv/tb_link_ack_nak.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_link_ack_nak;
    logic clk_sys, rst_n, linkActive, txTlpSent, fcMandReq, tlpReq, fcOtherReq, otherReq, fwdReady, clr;
    logic dllpValid, rxError, tlpRxActive, tlpEnd, tlpNullified, tlpReady, fwdValid, fcValid, pmValid;
    logic retryEmpty, purge, replayTimerReset, portError, protocolError, tlpMissing;
    logic txDone = 1'b0;
    logic [7:0] dllpType;
    logic [8:0] seen;
    logic [6:0] grant;
    logic [11:0] tlpSeq, fwdSeq, replySequence, expectedRxSequence, lastAckedSequence;
    logic [15:0] dllpCrcField, dllpCrcCalc, ackLatencyLimit;
    logic [23:0] dllpBody, fcData, pmData;
    logic [31:0] tlpCrcField, tlpCrcCalc;
    int miscompares, checkCount, n;

    link_ack_nak i_link_ack_nak (.clk_sys, .rst_n, .linkActive, .rxError, .dllpValid, .dllpType, .dllpBody,
        .dllpCrcField, .dllpCrcCalc, .tlpRxActive, .tlpEnd, .tlpSeq, .tlpNullified, .tlpCrcField, .tlpCrcCalc,
        .tlpReady, .fwdValid, .fwdReady, .fwdSeq, .fcValid, .fcData, .pmValid, .pmData, .txTlpSent, .txDone,
        .fcMandReq, .tlpReq, .fcOtherReq, .otherReq, .ackLatencyLimit, .grant, .replySequence,
        .expectedRxSequence, .lastAckedSequence, .retryEmpty, .purge, .replayTimerReset, .portError,
        .protocolError, .tlpMissing);
    link_partner_model i_link_partner_model (.clk_sys, .dllpValid, .dllpType, .dllpBody, .dllpCrcField,
        .dllpCrcCalc, .tlpRxActive, .tlpEnd, .tlpSeq, .tlpNullified, .tlpCrcField, .tlpCrcCalc, .rxError);

    // 100 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // transmitter finishes each granted item one cycle later
    always @(posedge clk_sys) txDone <= #10 |grant;
    // sticky record of one-cycle pulses, so a test may look a few cycles later
    always @(posedge clk_sys) seen <= clr ? 9'h000 :
        seen | {replayTimerReset, grant[3], grant[1], portError, protocolError, tlpMissing, purge, fcValid, pmValid};

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        checkCount++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cycles(input int k);
        repeat (k) @(posedge clk_sys);
        #10;
    endtask
    task automatic clear_seen();
        clr = 1'b1;
        cycles(1);
        clr = 1'b0;
    endtask
    // bounded wait for one grant bit; reply sequence only matters for Ack and Nak
    task automatic wait_grant(input int idx, input logic [11:0] rs);
        n = 0;
        while (grant[idx] !== 1'b1) begin
            cycles(1);
            n++;
            if (n > 40) begin
                miscompares++;
                $display("unexpected at %0t: no grant %0d", $time, idx);
                wrap_up();
            end
        end
        if (idx < 2) check({12'h000, replySequence}, {12'h000, rs});
    endtask
    task automatic tlp_case(input logic [11:0] s, input logic [2:0] k, input logic [5:0] e, input int g,
        input logic [11:0] rs);
        clear_seen();
        i_link_partner_model.send_tlp(s, k);
        if (g < 7) wait_grant(g, rs);
        cycles(4);
        check({18'h0, seen[5:0]}, {18'h0, e});
        $display("packet test %h kind %0d done", s, k);
    endtask
    task automatic dllp_case(input logic tx, input logic [7:0] t, input logic [23:0] b, input logic ok,
        input logic err, input logic [7:0] e);
        clear_seen();
        if (tx) begin
            txTlpSent = 1'b1;
            cycles(1);
            txTlpSent = 1'b0;
            check({23'h0, retryEmpty}, 24'h0);
        end
        i_link_partner_model.send_dllp(t, b, ok, err);
        cycles(8);
        check({16'h0, seen[7:0]}, {16'h0, e});
        check({23'h0, seen[8]}, {23'h0, e[2]});
        $display("control test type %h done", t);
    endtask

    initial begin
        rst_n = 1'b0;
        {linkActive, txTlpSent, fcMandReq, tlpReq, fcOtherReq, otherReq} = 6'h20;
        {fwdReady, clr} = 2'b11;
        ackLatencyLimit = 16'h0008;
        miscompares = 0;
        checkCount = 0;
        cycles(16);
        {rst_n, clr, linkActive} = 3'b100;
        cycles(2);
        linkActive = 1'b1;
        cycles(2);
        check({12'h0, expectedRxSequence}, 24'h0);
        check({12'h0, lastAckedSequence}, 24'hFFF);
        // stall the upper layer, fill the queue until it refuses, then drain
        fwdReady = 1'b0;
        for (int i = 0; i < 16; i++) i_link_partner_model.send_tlp(i[11:0], 3'h0);
        cycles(30);
        check({23'h0, tlpReady}, 24'h0);
        check({23'h0, seen[6]}, 24'h0);
        check({12'h0, expectedRxSequence}, 24'h010);
        fwdReady = 1'b1;
        n = 0;
        // look before each edge: every valid cycle here is one pop, in arrival order
        repeat (40) begin
            if (fwdValid === 1'b1) begin
                check({12'h0, fwdSeq}, n[23:0]);
                n++;
            end
            cycles(1);
        end
        check(n[23:0], 24'h10);
        check({23'h0, seen[6]}, 24'h1);
        $display("fill and drain test done");
        tlp_case(12'h010, 3'h0, 6'h00, 1, 12'h010);
        tlp_case(12'h011, 3'h1, 6'h20, 0, 12'h010);
        tlp_case(12'h011, 3'h0, 6'h00, 1, 12'h011);
        tlp_case(12'h812, 3'h0, 6'h00, 1, 12'h011);
        tlp_case(12'h012, 3'h2, 6'h00, 7, 12'h000);
        tlp_case(12'h012, 3'h3, 6'h20, 0, 12'h011);
        tlp_case(12'h012, 3'h0, 6'h00, 1, 12'h012);
        tlp_case(12'h812, 3'h0, 6'h08, 0, 12'h012);
        tlp_case(12'h013, 3'h0, 6'h00, 1, 12'h013);
        tlp_case(12'h000, 3'h4, 6'h00, 0, 12'h013);
        check({12'h0, expectedRxSequence}, 24'h014);
        dllp_case(1'b0, 8'h03, 24'hABCDEF, 1'b1, 1'b0, 8'h02);
        dllp_case(1'b0, 8'h04, 24'h13579B, 1'b1, 1'b0, 8'h01);
        dllp_case(1'b0, 8'h03, 24'h000000, 1'b0, 1'b0, 8'h20);
        dllp_case(1'b0, 8'h7E, 24'h000000, 1'b1, 1'b0, 8'h00);
        dllp_case(1'b0, 8'h01, 24'h000123, 1'b1, 1'b0, 8'h10);
        dllp_case(1'b0, 8'h01, 24'h000FFF, 1'b1, 1'b0, 8'h00);
        dllp_case(1'b0, 8'h03, 24'h111111, 1'b1, 1'b1, 8'h00);
        dllp_case(1'b1, 8'h01, 24'hFFF000, 1'b1, 1'b0, 8'h04);
        dllp_case(1'b1, 8'h02, 24'h000000, 1'b1, 1'b0, 8'h80);
        check(fcData, 24'hABCDEF);
        check(pmData, 24'h13579B);
        check({12'h0, lastAckedSequence}, 24'h000);
        // several requests at once, granted one by one in priority order
        {fcMandReq, tlpReq, fcOtherReq, otherReq} = 4'hF;
        wait_grant(2, 12'h000);
        fcMandReq = 1'b0;
        wait_grant(4, 12'h000);
        tlpReq = 1'b0;
        wait_grant(5, 12'h000);
        fcOtherReq = 1'b0;
        wait_grant(6, 12'h000);
        $display("priority test done");
        // a steady mandatory stream must still let the lowest class through once
        fcMandReq = 1'b1;
        repeat (15) begin
            cycles(1);
            wait_grant(2, 12'h000);
        end
        cycles(1);
        wait_grant(6, 12'h000);
        {fcMandReq, otherReq} = 2'b00;
        $display("fairness test done");
        linkActive = 1'b0;
        cycles(3);
        check({12'h0, expectedRxSequence}, 24'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
